// >>> dmrc_ctrl.sv
// Controller end: Wishbone registers, command issue, refresh scheduling
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dmrc_defs.svh"
module dmrc_ctrl
  import dmrc_pkg::*;
#(
  parameter int NUM_CH  = 2,
  parameter int REFI    = `DMRC_DN(`DMRC_REFI_NS),
  parameter int REFIPB  = `DMRC_DN(`DMRC_REFIPB_NS)
)
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  dmrc_link_if.ctrl        LINK
);

  if ((NUM_CH != 2) || (REFI < 4) || (REFI > 255) || (REFIPB < 4) || (REFIPB > REFI))
  begin : g_chk
    $error("dmrc_ctrl: unsupported parameter values");
  end

  localparam logic [7:0] REFI_C   = 8'(REFI);
  localparam logic [7:0] REFIPB_C = 8'(REFIPB);
  localparam logic [2:0] RFCAB_LO = 3'(`DMRC_UP(`DMRC_RFCAB_LO_NS));
  localparam logic [2:0] RFCAB_HI = 3'(`DMRC_UP(`DMRC_RFCAB_HI_NS));
  localparam logic [2:0] RFCPB_LO = 3'(`DMRC_UP(`DMRC_RFCPB_LO_NS));
  localparam logic [2:0] RFCPB_HI = 3'(`DMRC_UP(`DMRC_RFCPB_HI_NS));
  localparam logic [12:0] REF_WRAP = 13'(`DMRC_REF_PER_WIN - 1);

  // Refresh cycle time for the refresh kind and density
  function automatic logic [2:0] rfc_of(input logic pb, input logic hd);
    if (pb)
    begin
      rfc_of = hd ? RFCPB_HI : RFCPB_LO;
    end
    else
    begin
      rfc_of = hd ? RFCAB_HI : RFCAB_LO;
    end
  endfunction : rfc_of

  logic [4:0]  ctrl;
  logic        pend;
  logic [23:0] pend_cmd;
  logic        err;
  dmrc_byte_t  mr_data;
  logic [15:0] cal_dq;
  logic [15:0] cal_mil;
  logic [4:0]  gap;
  logic [4:0]  cap;
  logic        wb_wr;
  logic        wr_ok;
  logic        bad_cmd;
  logic        issue_ref;
  logic        issue_sw;
  logic        sel_ch;
  dmrc_cmd_e   pcode;
  logic        pch;
  logic [NUM_CH-1:0] due;
  logic [NUM_CH-1:0] extra;
  logic [NUM_CH-1:0] in_sr;
  logic [NUM_CH-1:0] rfc_busy;
  logic [NUM_CH-1:0] ref_req;
  logic [2:0]        bank_ptr [NUM_CH];
  logic [12:0]       ref_cnt  [NUM_CH];

  assign pcode = dmrc_cmd_e'(pend_cmd[`DMRC_CMD_CODE]);
  assign pch   = pend_cmd[`DMRC_CMD_CH];
  assign wb_wr = CYC_I && STB_I && WE_I && ACK_O && (SEL_I == 4'hf);
  assign wr_ok = wb_wr && (ADR_I == `DMRC_WB_CMD);
  // Mode register access to the reserved range is refused
  assign bad_cmd = ((DAT_I[`DMRC_CMD_CODE] == CMD_MR_WRITE) || (DAT_I[`DMRC_CMD_CODE] == CMD_MR_READ))
                   && (DAT_I[`DMRC_CMD_MA] >= `DMRC_MA_RSVD_LO)
                   && (DAT_I[`DMRC_CMD_MA] <= `DMRC_MA_RSVD_HI);

  // Arbiter: refresh first, lowest channel first, then software
  always_comb
  begin
    issue_ref = 1'b0;
    sel_ch    = 1'b0;
    issue_sw  = 1'b0;
    for (int c = NUM_CH - 1; c >= 0; c--)
    begin
      if (ref_req[c] && (gap == 5'h00))
      begin
        issue_ref = 1'b1;
        sel_ch    = c[0];
      end
    end
    if (!issue_ref && pend && (gap == 5'h00) && !rfc_busy[pch]
        && !((pcode == CMD_SR_ENTER) && extra[pch]))
    begin
      issue_sw = 1'b1;
    end
  end

  // Link command register
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      LINK.cmd_valid <= 1'b0;
      LINK.cmd_code  <= CMD_NONE;
      LINK.cmd_ch    <= 1'b0;
      LINK.cmd_bank  <= 3'h0;
      LINK.cmd_ma    <= 6'h00;
      LINK.cmd_op    <= 8'h00;
    end
    else
    begin
      LINK.cmd_valid <= issue_ref || issue_sw;
      LINK.cmd_code  <= issue_ref ? (ctrl[`DMRC_CTRL_PB] ? CMD_REF_BANK : CMD_REF_ALL)
                                  : (issue_sw ? pcode : CMD_NONE);
      LINK.cmd_ch    <= issue_ref ? sel_ch : pch;
      LINK.cmd_bank  <= issue_ref ? bank_ptr[sel_ch] : pend_cmd[`DMRC_CMD_BANK];
      LINK.cmd_ma    <= pend_cmd[`DMRC_CMD_MA];
      LINK.cmd_op    <= pend_cmd[`DMRC_CMD_OP];
    end
  end

  // Spacing after mode register access and calibration
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      gap <= 5'h00;
    end
    else if (issue_sw && (pcode == CMD_MULTI))
    begin
      gap <= `DMRC_CAL_BITS + 5'h01;
    end
    else if (issue_sw && ((pcode == CMD_MR_WRITE) || (pcode == CMD_MR_READ)))
    begin
      gap <= `DMRC_MR_GAP;
    end
    else if (gap != 5'h00)
    begin
      gap <= gap - 5'h01;
    end
  end

  // Software registers; error set wins over its clear
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ctrl     <= 5'h00;
      pend     <= 1'b0;
      pend_cmd <= 24'h000000;
      err      <= 1'b0;
    end
    else
    begin
      if (wb_wr && (ADR_I == `DMRC_WB_CTRL))
      begin
        ctrl <= DAT_I[4:0];
      end
      if (wr_ok && !pend && !bad_cmd)
      begin
        pend     <= 1'b1;
        pend_cmd <= DAT_I[23:0];
      end
      else if (issue_sw)
      begin
        pend <= 1'b0;
      end
      if (wr_ok && (pend || bad_cmd))
      begin
        err <= 1'b1;
      end
      else if (wb_wr && (ADR_I == `DMRC_WB_STAT) && DAT_I[`DMRC_STAT_ERR])
      begin
        err <= 1'b0;
      end
    end
  end

  // Read data and calibration capture, low bit first
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      mr_data <= 8'h00;
      cal_dq  <= 16'h0000;
      cal_mil <= 16'h0000;
      cap     <= 5'h00;
    end
    else
    begin
      if (LINK.rd_valid)
      begin
        mr_data <= LINK.dq_out[7:0];
      end
      if (issue_sw && (pcode == CMD_MULTI))
      begin
        cap <= `DMRC_CAL_BITS;
      end
      else if ((cap != 5'h00) && LINK.dq_oe)
      begin
        cap     <= cap - 5'h01;
        cal_dq  <= {LINK.dq_out[0], cal_dq[15:1]};
        cal_mil <= {LINK.mil_oe & LINK.mil_out[0], cal_mil[15:1]};
      end
    end
  end

  // Per-channel refresh schedulers, own timers and state, sharing the control bits and one issue slot
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [7:0] ivl;
    logic [2:0] rfc;
    logic       mine;
    logic       refd;
    assign mine = (LINK.cmd_valid && (LINK.cmd_ch == 1'(c)));
    assign refd = mine && ((LINK.cmd_code == CMD_REF_ALL) || (LINK.cmd_code == CMD_REF_BANK));
    assign rfc_busy[c] = (rfc != 3'h0) || refd;
    assign ref_req[c]  = ctrl[`DMRC_CTRL_EN] && (due[c] || extra[c])
                         && !in_sr[c] && !rfc_busy[c];

    // Interval timer; reloads one short so the period is exact
    always_ff @(posedge MCLK)
    begin
      if (RST)
      begin
        ivl    <= 8'h00;
        due[c] <= 1'b0;
      end
      else
      begin
        if (ivl == 8'h00)
        begin
          ivl <= ((ctrl[`DMRC_CTRL_PB] ? REFIPB_C : REFI_C) >> ctrl[`DMRC_CTRL_RT]) - 8'h01;
        end
        else
        begin
          ivl <= ivl - 8'h01;
        end
        if ((ivl == 8'h00) && !in_sr[c])
        begin
          due[c] <= 1'b1;
        end
        else if (refd || in_sr[c])
        begin
          due[c] <= 1'b0;
        end
      end
    end

    // Refresh cycle timer, self refresh state, counters
    always_ff @(posedge MCLK)
    begin
      if (RST)
      begin
        rfc         <= 3'h0;
        extra[c]    <= 1'b0;
        in_sr[c]    <= 1'b0;
        bank_ptr[c] <= 3'h0;
        ref_cnt[c]  <= 13'h0000;
      end
      else
      begin
        if (refd)
        begin
          rfc         <= rfc_of(LINK.cmd_code == CMD_REF_BANK, ctrl[`DMRC_CTRL_HD]) - 3'h1;
          extra[c]    <= 1'b0;
          bank_ptr[c] <= bank_ptr[c] + 3'h1;
          ref_cnt[c]  <= (ref_cnt[c] == REF_WRAP) ? 13'h0000 : ref_cnt[c] + 13'h0001;
        end
        else if (rfc != 3'h0)
        begin
          rfc <= rfc - 3'h1;
        end
        if (mine && (LINK.cmd_code == CMD_SR_EXIT))
        begin
          extra[c] <= 1'b1;
          in_sr[c] <= 1'b0;
        end
        else if (mine && (LINK.cmd_code == CMD_SR_ENTER))
        begin
          in_sr[c] <= 1'b1;
        end
      end
    end
  end

  // Wishbone classic slave: ack one cycle after request
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end
    else
    begin
      ACK_O <= CYC_I && STB_I && !ACK_O;
      if (CYC_I && STB_I && !ACK_O)
      begin
        case (ADR_I)
          `DMRC_WB_CTRL:   DAT_O <= {27'h0, ctrl};
          `DMRC_WB_CMD:    DAT_O <= {8'h00, pend_cmd};
          `DMRC_WB_STAT:   DAT_O <= {12'h000, in_sr, extra, mr_data, 6'h00, err, pend};
          `DMRC_WB_CAL:    DAT_O <= {cal_mil, cal_dq};
          `DMRC_WB_REFCNT: DAT_O <= {3'h0, ref_cnt[1], 3'h0, ref_cnt[0]};
          default:         DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : dmrc_ctrl

// >>> dmrc_defs.svh
// Constants for the mode register, calibration and refresh block
`ifndef DMRC_DEFS_SVH
`define DMRC_DEFS_SVH
// Mode register addresses
`define DMRC_MA_REPAIR     6'h19
`define DMRC_MA_TEST_A     6'h1e
`define DMRC_MA_CAL_FIRST  6'h20
`define DMRC_MA_RSVD_LO    6'h21
`define DMRC_MA_RSVD_HI    6'h26
`define DMRC_MA_TEST_B     6'h27
`define DMRC_MA_CAL_SECOND 6'h28
// Reset values and calibration operand
`define DMRC_CAL_FIRST_RST  8'h5a
`define DMRC_CAL_SECOND_RST 8'h3c
`define DMRC_OP_RD_CAL      7'h23
`define DMRC_CAL_BITS       5'h10
// Timing in its own units and derived cycle counts
`define DMRC_CLK_NS      40
`define DMRC_REFI_NS     3904
`define DMRC_REFIPB_NS   488
`define DMRC_RFCAB_LO_NS 130
`define DMRC_RFCAB_HI_NS 180
`define DMRC_RFCPB_LO_NS 60
`define DMRC_RFCPB_HI_NS 90
`define DMRC_REF_PER_WIN 8192
`define DMRC_DN(ns) ((ns) / `DMRC_CLK_NS)
`define DMRC_UP(ns) (((ns) + `DMRC_CLK_NS - 1) / `DMRC_CLK_NS)
`define DMRC_MR_GAP 5'h02
// Wishbone register byte offsets
`define DMRC_WB_CTRL   5'h00
`define DMRC_WB_CMD    5'h04
`define DMRC_WB_STAT   5'h08
`define DMRC_WB_CAL    5'h0c
`define DMRC_WB_REFCNT 5'h10
// Control fields
`define DMRC_CTRL_EN  0
`define DMRC_CTRL_PB  1
`define DMRC_CTRL_RT  3:2
`define DMRC_CTRL_HD  4
// Command fields
`define DMRC_CMD_CODE 2:0
`define DMRC_CMD_CH   3
`define DMRC_CMD_BANK 6:4
`define DMRC_CMD_MA   13:8
`define DMRC_CMD_OP   23:16
// Status fields
`define DMRC_STAT_BUSY 0
`define DMRC_STAT_ERR  1
`endif

// >>> dmrc_device.sv
// Device end: mode registers, calibration stream, refresh tracking
// What this block does
// - Repair register: one read-only bit per bank
// - Test registers accept writes, data ignored
// - First pattern resets to 5a, writable
// - Second pattern resets to 3c, writable
// - Calibration returns first byte then second
// - Pattern on all data and mask lanes
// - Each byte sent low bit first
// - Mask lanes never inverted
// - Read inversion off: mask lanes undriven
// - No bus inversion encoding on pattern
// - Extra refresh between exit and entry
// - 8192 refreshes per refresh window
// - Average refresh spacing 3.904us / 488ns
// - Wait all-bank refresh cycle time
// - Wait per-bank refresh cycle time
// - Refresh tracked separately per channel
// - Invert mask bit complements its lane
`timescale 1ns/1ps
`include "dmrc_defs.svh"
module dmrc_device
  import dmrc_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int NUM_CH    = 2
)
(
  input  wire logic              MCLK,
  input  wire logic              RST,
  dmrc_link_if.dev               LINK,
  input  wire logic [7:0]        REPAIR_AVAIL,
  input  wire logic [7:0]        INV_MASK_LOW,
  input  wire logic [7:0]        INV_MASK_HIGH,
  input  wire logic              READ_INV_EN,
  output logic      [7:0]        CAL_FIRST,
  output logic      [7:0]        CAL_SECOND,
  output logic      [NUM_CH-1:0] REFRESH_ERR
);

  // Elaboration checks
  if (NUM_BANKS != 8)
  begin : g_bank_chk
    $error("dmrc_device: NUM_BANKS must be 8");
  end
  if (NUM_CH != 2)
  begin : g_ch_chk
    $error("dmrc_device: NUM_CH must be 2");
  end

  // Lane values for one serial bit, inverted per lane by the mask
  function automatic logic [15:0] lanes_of(input logic b,
                                           input logic [15:0] mask);
    lanes_of = {16{b}} ^ mask;
  endfunction : lanes_of

  // Value returned by a mode register read
  function automatic dmrc_byte_t mr_value(input logic [5:0] ma,
                                          input logic [7:0] repair);
    if (ma == `DMRC_MA_REPAIR)
    begin
      mr_value = repair;
    end
    else
    begin
      mr_value = 8'h00;
    end
  endfunction : mr_value

  dmrc_dev_state_e state;
  logic [4:0]      idx;
  logic [15:0]     pat;
  logic [15:0]     inv_mask;
  logic            cal_start;
  logic            mr_wr;
  logic            mr_rd;
  logic            cur_bit;
  logic [NUM_CH-1:0] extra_owed;

  // Command decode
  assign inv_mask  = {INV_MASK_HIGH, INV_MASK_LOW};
  assign mr_wr     = LINK.cmd_valid && (LINK.cmd_code == CMD_MR_WRITE);
  assign mr_rd     = LINK.cmd_valid && (LINK.cmd_code == CMD_MR_READ)
                     && (state == DEV_IDLE);
  assign cal_start = LINK.cmd_valid && (LINK.cmd_code == CMD_MULTI)
                     && (LINK.cmd_op[6:0] == `DMRC_OP_RD_CAL)
                     && (state == DEV_IDLE);

  // Serial bit in flight: first byte, then second, low bit first
  assign cur_bit = pat[idx[3:0]];

  // Calibration pattern registers
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      CAL_FIRST  <= `DMRC_CAL_FIRST_RST;
      CAL_SECOND <= `DMRC_CAL_SECOND_RST;
    end
    else if (mr_wr)
    begin
      // Test addresses take the write but store nothing
      case (LINK.cmd_ma)
        `DMRC_MA_CAL_FIRST:  CAL_FIRST  <= LINK.cmd_op;
        `DMRC_MA_CAL_SECOND: CAL_SECOND <= LINK.cmd_op;
        `DMRC_MA_TEST_A:     ;
        `DMRC_MA_TEST_B:     ;
        default:             ;
      endcase
    end
  end

  // Calibration sequencer
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state <= DEV_IDLE;
      idx   <= 5'h00;
      pat   <= 16'h0000;
    end
    else
    begin
      case (state)
        DEV_IDLE:
        begin
          if (cal_start)
          begin
            pat   <= {CAL_SECOND, CAL_FIRST};
            idx   <= 5'h00;
            state <= DEV_CALIB;
          end
        end
        DEV_CALIB:
        begin
          if (idx == `DMRC_CAL_BITS - 5'h01)
          begin
            idx   <= 5'h00;
            state <= DEV_IDLE;
          end
          else
          begin
            idx <= idx + 5'h01;
          end
        end
        default:
        begin
          state <= DEV_IDLE;
          idx   <= 5'h00;
        end
      endcase
    end
  end

  // Data and mask lane drivers
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      LINK.dq_out   <= 16'h0000;
      LINK.dq_oe    <= 1'b0;
      LINK.mil_out  <= 2'b00;
      LINK.mil_oe   <= 1'b0;
      LINK.rd_valid <= 1'b0;
    end
    else if (state == DEV_CALIB)
    begin
      // Pattern sent raw; no bus inversion coding applied
      LINK.dq_out   <= lanes_of(cur_bit, inv_mask);
      LINK.dq_oe    <= 1'b1;
      LINK.mil_out  <= {2{cur_bit}};
      LINK.mil_oe   <= READ_INV_EN;
      LINK.rd_valid <= 1'b0;
    end
    else if (mr_rd)
    begin
      LINK.dq_out   <= {8'h00, mr_value(LINK.cmd_ma, REPAIR_AVAIL)};
      LINK.dq_oe    <= 1'b1;
      LINK.mil_out  <= 2'b00;
      LINK.mil_oe   <= 1'b0;
      LINK.rd_valid <= 1'b1;
    end
    else
    begin
      LINK.dq_out   <= 16'h0000;
      LINK.dq_oe    <= 1'b0;
      LINK.mil_out  <= 2'b00;
      LINK.mil_oe   <= 1'b0;
      LINK.rd_valid <= 1'b0;
    end
  end

  // Per-channel self refresh bookkeeping
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic hit;
    logic is_ref;
    assign hit    = LINK.cmd_valid && (LINK.cmd_ch == 1'(c));
    assign is_ref = (LINK.cmd_code == CMD_REF_ALL)
                    || (LINK.cmd_code == CMD_REF_BANK);

    // Extra refresh owed after exit, paid by any refresh
    always_ff @(posedge MCLK)
    begin
      if (RST)
      begin
        extra_owed[c] <= 1'b0;
      end
      else if (hit)
      begin
        if (LINK.cmd_code == CMD_SR_EXIT)
        begin
          extra_owed[c] <= 1'b1;
        end
        else if (is_ref)
        begin
          extra_owed[c] <= 1'b0;
        end
      end
    end

    // Sticky flag: entry seen while the extra refresh was owed
    always_ff @(posedge MCLK)
    begin
      if (RST)
      begin
        REFRESH_ERR[c] <= 1'b0;
      end
      else if (hit && (LINK.cmd_code == CMD_SR_ENTER) && extra_owed[c])
      begin
        REFRESH_ERR[c] <= 1'b1;
      end
    end
  end

endmodule : dmrc_device

// >>> dmrc_link_if.sv
// Command and data link between controller and device
`timescale 1ns/1ps
interface dmrc_link_if;
  import dmrc_pkg::*;
  logic        cmd_valid;
  dmrc_cmd_e   cmd_code;
  logic        cmd_ch;
  logic [2:0]  cmd_bank;
  logic [5:0]  cmd_ma;
  dmrc_byte_t  cmd_op;
  logic [15:0] dq_out;
  logic        dq_oe;
  logic [1:0]  mil_out;
  logic        mil_oe;
  logic        rd_valid;
  modport ctrl (
    output cmd_valid, cmd_code, cmd_ch, cmd_bank, cmd_ma, cmd_op,
    input  dq_out, dq_oe, mil_out, mil_oe, rd_valid
  );
  modport dev (
    input  cmd_valid, cmd_code, cmd_ch, cmd_bank, cmd_ma, cmd_op,
    output dq_out, dq_oe, mil_out, mil_oe, rd_valid
  );
endinterface : dmrc_link_if

// >>> dmrc_monitor.sv
// Link protocol checker between controller and device
`timescale 1ns/1ps
`include "dmrc_defs.svh"
module dmrc_monitor
  import dmrc_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        cmd_valid,
  input dmrc_cmd_e        cmd_code,
  input wire logic        cmd_ch,
  input wire logic [2:0]  cmd_bank,
  input wire logic [5:0]  cmd_ma,
  input dmrc_byte_t       cmd_op,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic [1:0]  mil_out,
  input wire logic        mil_oe,
  input wire logic        rd_valid
);
  default clocking mon_cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // Decoded link commands
  wire logic cal_go = cmd_valid && cmd_code == CMD_MULTI && cmd_op[6:0] == `DMRC_OP_RD_CAL;
  wire logic mr_cmd = cmd_valid && cmd_code inside {CMD_MR_WRITE, CMD_MR_READ};
  wire logic ref_cmd = cmd_valid && cmd_code inside {CMD_REF_ALL, CMD_REF_BANK};
  logic [1:0] owed;

  // Extra refresh owed per channel after self refresh exit
  always_ff @(posedge MCLK)
  begin
    if (RST)
      owed <= 2'b00;
    else if (cmd_valid && cmd_code == CMD_SR_EXIT)
      owed[cmd_ch] <= 1'b1;
    else if (ref_cmd)
      owed[cmd_ch] <= 1'b0;
  end

  // One load cycle, sixteen pattern bits, then lanes released
  calib_stream_a: assert property (cal_go |=> !dq_oe ##1 dq_oe [*8] ##1 dq_oe [*8] ##1 !dq_oe)
    else $error("calibration stream length wrong");
  calib_quiet_a: assert property (cal_go |=> !cmd_valid [*8] ##1 !cmd_valid [*8] ##1 !cmd_valid)
    else $error("command during calibration stream");
  mask_true_a: assert property (mil_oe |-> dq_oe && mil_out[0] == mil_out[1])
    else $error("mask lanes differ or drive alone");
  mr_answer_a: assert property (cmd_valid && cmd_code == CMD_MR_READ |=> rd_valid && dq_oe)
    else $error("mode register read not answered");
  read_cause_a: assert property (rd_valid |-> $past(cmd_valid) && $past(cmd_code) == CMD_MR_READ)
    else $error("read data without read command");
  mr_gap_a: assert property (mr_cmd |=> !cmd_valid)
    else $error("mode register access spacing broken");
  no_reserved_a: assert property (mr_cmd |-> !(cmd_ma inside {[`DMRC_MA_RSVD_LO:`DMRC_MA_RSVD_HI]}))
    else $error("reserved mode register accessed");
  rfc_all0_a: assert property (cmd_valid && cmd_code == CMD_REF_ALL && !cmd_ch |=> !(cmd_valid && !cmd_ch) [*3])
    else $error("channel 0 all-bank refresh time broken");
  rfc_all1_a: assert property (cmd_valid && cmd_code == CMD_REF_ALL && cmd_ch |=> !(cmd_valid && cmd_ch) [*3])
    else $error("channel 1 all-bank refresh time broken");
  rfc_bank_a: assert property (cmd_valid && cmd_code == CMD_REF_BANK |=> !(cmd_valid && cmd_ch == $past(cmd_ch)))
    else $error("per-bank refresh time broken");
  sr_entry_a: assert property (cmd_valid && cmd_code == CMD_SR_ENTER |-> !owed[cmd_ch])
    else $error("self refresh entry with extra refresh owed");

  // Main scenarios reached
  calib_c: cover property (cal_go);
  bank_c: cover property (cmd_valid && cmd_code == CMD_REF_BANK);
  exit_c: cover property (cmd_valid && cmd_code == CMD_SR_EXIT);
endmodule : dmrc_monitor

// >>> dmrc_pkg.sv
// Types shared by both ends of the link
package dmrc_pkg;
  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_MR_WRITE = 3'h1,
    CMD_MR_READ  = 3'h2,
    CMD_MULTI    = 3'h3,
    CMD_REF_ALL  = 3'h4,
    CMD_REF_BANK = 3'h5,
    CMD_SR_ENTER = 3'h6,
    CMD_SR_EXIT  = 3'h7
  } dmrc_cmd_e;
  typedef enum logic [1:0] {
    DEV_IDLE  = 2'b01,
    DEV_CALIB = 2'b10
  } dmrc_dev_state_e;
  typedef logic [7:0] dmrc_byte_t;
endpackage : dmrc_pkg

// >>> dram_mode_reg_calib_refresh_tb.sv
// Bench driving the controller registers and the device side inputs
`timescale 1ns/1ps
module dram_mode_reg_calib_refresh_tb;
  import dmrc_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, rinv;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat, q, c0;
  logic [7:0]  repair, invl, invh, calf, cals;
  logic [1:0]  referr;
  int          errors, cmp_count, d;
  logic [31:0] ctl [4] = '{32'h1, 32'h5, 32'h9, 32'h3};
  int          per [4] = '{40, 20, 10, 8};

  dmrc_link_if dmrc_link_if_i ();
  dmrc_ctrl #(.REFI(40), .REFIPB(8)) dmrc_ctrl_i (.MCLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .LINK(dmrc_link_if_i));
  dmrc_device dmrc_device_i (.MCLK(clk), .RST(rst), .LINK(dmrc_link_if_i), .REPAIR_AVAIL(repair),
    .INV_MASK_LOW(invl), .INV_MASK_HIGH(invh), .READ_INV_EN(rinv), .CAL_FIRST(calf), .CAL_SECOND(cals),
    .REFRESH_ERR(referr));
  dmrc_monitor dmrc_monitor_i (.MCLK(clk), .RST(rst), .cmd_valid(dmrc_link_if_i.cmd_valid),
    .cmd_code(dmrc_link_if_i.cmd_code), .cmd_ch(dmrc_link_if_i.cmd_ch), .cmd_bank(dmrc_link_if_i.cmd_bank),
    .cmd_ma(dmrc_link_if_i.cmd_ma), .cmd_op(dmrc_link_if_i.cmd_op), .dq_out(dmrc_link_if_i.dq_out),
    .dq_oe(dmrc_link_if_i.dq_oe), .mil_out(dmrc_link_if_i.mil_out), .mil_oe(dmrc_link_if_i.mil_oe),
    .rd_valid(dmrc_link_if_i.rd_valid));

  // Free running 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic hang();
    errors++;
    $display("ERROR %0t wait ran out", $time);
    conclude();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dat;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (n >= 40)
      hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Launch a link command and wait until it leaves
  task automatic cmd(input dmrc_cmd_e c, input logic [5:0] ma, input logic [7:0] op);
    int n;
    n = 0;
    wb(1'b1, 5'h04, {8'h00, op, 2'b00, ma, 5'h00, c});
    do
    begin
      wb(1'b0, 5'h08, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 40);
    if (n >= 40)
      hang();
  endtask : cmd

  // Run calibration and compare lane 0 and mask lane 0 streams
  task automatic calib(input logic [15:0] pat, input logic inv0, input logic rie);
    rinv <= rie;
    invl <= {7'h00, inv0};
    @(posedge clk);
    cmd(CMD_MULTI, 6'h00, 8'h23);
    // Let the sixteen bit stream finish before reading the capture
    repeat (20) @(posedge clk);
    wb(1'b0, 5'h0c, 32'h0);
    chk(q, {rie ? pat : 16'h0000, inv0 ? ~pat : pat});
  endtask : calib

  // Main sequence
  initial
  begin
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    repair = 8'hb4;
    invl = 8'h00;
    invh = 8'ha5;
    rinv = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({24'h0, calf}, 32'h5a);
    chk({24'h0, cals}, 32'h3c);
    calib(16'h3c5a, 1'b0, 1'b1);
    calib(16'h3c5a, 1'b1, 1'b1);
    calib(16'h3c5a, 1'b0, 1'b0);
    cmd(CMD_MR_WRITE, 6'h1e, 8'hff);
    cmd(CMD_MR_WRITE, 6'h27, 8'h00);
    chk({16'h0, cals, calf}, 32'h3c5a);
    cmd(CMD_MR_WRITE, 6'h20, 8'hc1);
    cmd(CMD_MR_WRITE, 6'h28, 8'h27);
    chk({16'h0, cals, calf}, 32'h27c1);
    calib(16'h27c1, 1'b0, 1'b1);
    repeat (2)
    begin
      repair <= ~repair;
      cmd(CMD_MR_READ, 6'h19, 8'h00);
      wb(1'b0, 5'h08, 32'h0);
      chk({24'h0, q[15:8]}, {24'h0, repair});
    end
    cmd(CMD_MR_READ, 6'h22, 8'h00);
    wb(1'b0, 5'h08, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    wb(1'b1, 5'h08, 32'h2);
    wb(1'b0, 5'h08, 32'h0);
    chk({31'h0, q[1]}, 32'h0);
    // Refresh rate per mode, both channels alike
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 5'h00, ctl[i]);
      wb(1'b0, 5'h10, 32'h0);
      c0 = q;
      repeat (400) @(posedge clk);
      wb(1'b0, 5'h10, 32'h0);
      d = {19'h0, q[12:0] - c0[12:0]};
      chk({31'h0, d >= 400 / per[i] - 2 && d <= 400 / per[i] + 2}, 32'h1);
      d = {19'h0, q[28:16] - c0[28:16]};
      chk({31'h0, d >= 400 / per[i] - 2 && d <= 400 / per[i] + 2}, 32'h1);
    end
    // Self refresh on channel 0 only
    wb(1'b1, 5'h00, 32'h1);
    cmd(CMD_SR_ENTER, 6'h00, 8'h00);
    wb(1'b0, 5'h10, 32'h0);
    c0 = q;
    repeat (200) @(posedge clk);
    wb(1'b0, 5'h10, 32'h0);
    chk({19'h0, q[12:0] - c0[12:0]}, 32'h0);
    d = {19'h0, q[28:16] - c0[28:16]};
    chk({31'h0, d >= 3 && d <= 7}, 32'h1);
    cmd(CMD_SR_EXIT, 6'h00, 8'h00);
    cmd(CMD_SR_ENTER, 6'h00, 8'h00);
    wb(1'b0, 5'h08, 32'h0);
    chk({28'h0, q[19:16]}, 32'h4);
    chk({30'h0, referr}, 32'h0);
    cmd(CMD_SR_EXIT, 6'h00, 8'h00);
    // Reset in mid-run restores the pattern defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({16'h0, cals, calf}, 32'h3c5a);
    wb(1'b0, 5'h00, 32'h0);
    chk(q, 32'h0);
    conclude();
  end
endmodule : dram_mode_reg_calib_refresh_tb
